/* File: inc/mx_defs.svh */
// constants and bit positions shared by both ends of the mixer stream link
// Function
// - source drives 16-bit samples on stream clock
// - source valid only with a real sample
// - sideband 128 bits, timestamp in 63:0
// - gate 71:64, sync 79:72, pulse-per-second 87:80
// - bits 91:88 give samples per clock
// - bit 92: 0 in-phase, 1 quadrature
// - bits 94:93 format 8/16/24/32-bit
// - bit 95: 0 real, 1 complex
// - channel in 103:96, 127:104 reserved
// - output data twice the output resolution
// - output valid only with a mixed result
// - oscillator supplies 18-bit complex samples
// - oscillator I in 17:0, Q 41:24
// - oscillator valid only with a sample
// - mode: bypass, mixer, oscillator, zero; reset bypass
// - stream clock, active-low reset: synchronous in the mixer, asynchronous in the peer
`ifndef MX_DEFS_SVH
`define MX_DEFS_SVH

// ==========================================================
// stream widths
`define MX_IN_W        16
`define MX_USER_W      128
`define MX_OSC_W       48
`define MX_OSC_RES     18
`define MX_OSC_I_LSB   0
`define MX_OSC_Q_LSB   24
`define MX_OUT_RES_DEF 16
`define MX_PROD_W      34

// ==========================================================
// sideband field positions
`define MX_TS_MSB      63
`define MX_CHAN_LSB    96
`define MX_CHAN_MSB    103
`define MX_RSV_LSB     104
`define MX_RSV_W       24

// ==========================================================
// reset values
`define MX_MODE_RST    2'h0

// ==========================================================
// peer register byte offsets
`define MX_A_CTRL      8'h00
`define MX_A_SAMPLE    8'h04
`define MX_A_USER0     8'h08
`define MX_A_USER1     8'h0C
`define MX_A_USER2     8'h10
`define MX_A_USER3     8'h14
`define MX_A_OSC_I     8'h18
`define MX_A_OSC_Q     8'h1C
`define MX_A_OUT_I     8'h20
`define MX_A_OUT_Q     8'h24
`define MX_A_OUT_TS    8'h28
`define MX_A_STATUS    8'h2C

`endif

/* File: inc/mx_if.sv */
// stream link between the mixer and its surrounding logic
`timescale 1ns/100ps
`include "mx_defs.svh"

interface mx_if
    import mx_pkg::*;
#(
    parameter int OUT_RES = `MX_OUT_RES_DEF
);
    logic [`MX_IN_W-1:0]   in_data;
    logic                  in_valid;
    logic [`MX_USER_W-1:0] in_user;
    logic [`MX_OSC_W-1:0]  osc_data;
    logic                  osc_valid;
    logic [2*OUT_RES-1:0]  out_data;
    logic                  out_valid;
    logic [`MX_USER_W-1:0] out_user;
    mx_mode_t              mode;

    modport dev (
        input  in_data,
        input  in_valid,
        input  in_user,
        input  osc_data,
        input  osc_valid,
        input  mode,
        output out_data,
        output out_valid,
        output out_user
    );

    modport peer (
        output in_data,
        output in_valid,
        output in_user,
        output osc_data,
        output osc_valid,
        output mode,
        input  out_data,
        input  out_valid,
        input  out_user
    );
endinterface : mx_if

/* File: inc/mx_pkg.sv */
// types shared by both ends of the mixer stream link
package mx_pkg;

    // ==========================================================
    // operating modes, in setting order 00..11
    typedef enum logic [1:0] {
        MX_BYPASS,
        MX_MIX,
        MX_OSC,
        MX_ZERO
    } mx_mode_t;

    // ==========================================================
    // sample format codes
    typedef enum logic [1:0] {
        MX_FMT8,
        MX_FMT16,
        MX_FMT24,
        MX_FMT32
    } mx_fmt_t;

    // ==========================================================
    // sideband word, msb first
    typedef struct packed {
        logic [23:0] rsv;
        logic [7:0]  chan;
        logic        cplx;
        mx_fmt_t     fmt;
        logic        quad;
        logic [3:0]  spc;
        logic [7:0]  pulse_per_second;
        logic [7:0]  sync;
        logic [7:0]  gate;
        logic [63:0] ts;
    } mx_user_t;

endpackage : mx_pkg

/* File: rtl/mx_mixer.sv */
// mixer end: latches oscillator samples, mixes input stream, drives result stream
`timescale 1ns/100ps
`include "mx_defs.svh"

module mx_mixer
    import mx_pkg::*;
#(
    parameter int OUT_RES = `MX_OUT_RES_DEF
)(
    input wire logic hclk,
    input wire logic hresetn,
    mx_if.dev        lnk
);

    // ==========================================================
    // elaboration checks
    if (OUT_RES < 2 || OUT_RES > `MX_PROD_W - 1) begin : g_bad_res
        $error("mx_mixer: OUT_RES out of range");
    end
    if ($bits(lnk.out_data) != 2 * OUT_RES) begin : g_bad_if
        $error("mx_mixer: interface width mismatch");
    end

    // ==========================================================
    // state
    logic signed [`MX_OSC_RES-1:0] osc_i_q;
    logic signed [`MX_OSC_RES-1:0] osc_q_q;
    logic [2*OUT_RES-1:0]          out_data_q;
    logic                          out_valid_q;
    logic [`MX_USER_W-1:0]         out_user_q;
    logic signed [`MX_IN_W-1:0]    smp;
    logic signed [`MX_PROD_W-1:0]  res_i;
    logic signed [`MX_PROD_W-1:0]  res_q;

    // top bits of a full-scale 34-bit value; bit 33 only repeats the sign
    function automatic logic [OUT_RES-1:0] mx_top(input logic signed [`MX_PROD_W-1:0] v);
        return v[`MX_PROD_W-2 -: OUT_RES];
    endfunction : mx_top

    // ==========================================================
    // oscillator sample hold
    // the oscillator may run at its own pace; the last sample is mixed
    always_ff @(posedge hclk) begin
        if (!hresetn) begin
            osc_i_q <= '0;
            osc_q_q <= '0;
        end else if (lnk.osc_valid) begin
            osc_i_q <= lnk.osc_data[`MX_OSC_I_LSB +: `MX_OSC_RES];
            osc_q_q <= lnk.osc_data[`MX_OSC_Q_LSB +: `MX_OSC_RES];
        end
    end

    // ==========================================================
    // datapath, all modes scaled so full scale lands on the same bits
    always_comb begin
        smp = signed'(lnk.in_data);
        case (lnk.mode)
            MX_BYPASS: begin
                res_i = {smp[`MX_IN_W-1], smp, 17'h0};
                res_q = '0;
            end
            MX_MIX: begin
                // widen both factors first so no tool sizes the product from its operands
                res_i = `MX_PROD_W'(smp) * `MX_PROD_W'(osc_i_q);
                res_q = `MX_PROD_W'(smp) * `MX_PROD_W'(osc_q_q);
            end
            MX_OSC: begin
                res_i = {osc_i_q[`MX_OSC_RES-1], osc_i_q, 15'h0};
                res_q = {osc_q_q[`MX_OSC_RES-1], osc_q_q, 15'h0};
            end
            MX_ZERO: begin
                res_i = '0;
                res_q = '0;
            end
            default: begin
                res_i = '0;
                res_q = '0;
            end
        endcase
    end

    // ==========================================================
    // output stage, one cycle after the input beat
    always_ff @(posedge hclk) begin
        if (!hresetn) begin
            out_valid_q <= 1'b0;
        end else begin
            out_valid_q <= lnk.in_valid;
        end
    end

    always_ff @(posedge hclk) begin
        if (!hresetn) begin
            out_data_q <= '0;
            out_user_q <= '0;
        end else if (lnk.in_valid) begin
            out_data_q <= {mx_top(res_q), mx_top(res_i)};
            // sideband passes untouched so fields keep their meaning
            out_user_q <= lnk.in_user;
        end
    end

    assign lnk.out_data  = out_data_q;
    assign lnk.out_valid = out_valid_q;
    assign lnk.out_user  = out_user_q;

endmodule : mx_mixer

/* File: rtl/mx_peer.sv */
// surrounding-logic end: AHB-Lite registers feed the streams and capture results
//
// The AHB-Lite register port and the address map were decided locally.
`timescale 1ns/100ps
`include "mx_defs.svh"

module mx_peer
    import mx_pkg::*;
#(
    parameter int OUT_RES = `MX_OUT_RES_DEF
)(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    mx_if.peer               lnk
);

    // ==========================================================
    // elaboration checks
    if (OUT_RES < 2 || OUT_RES > 32) begin : g_bad_res
        $error("mx_peer: OUT_RES must fit one bus word");
    end
    if ($bits(lnk.out_data) != 2 * OUT_RES) begin : g_bad_if
        $error("mx_peer: interface width mismatch");
    end

    // ==========================================================
    // state
    logic                     wr_q;
    logic                     rd_q;
    logic [7:0]               addr_q;
    logic                     hreadyout_q;
    logic [31:0]              hrdata_q;
    mx_mode_t                 mode_q;
    logic [`MX_RSV_LSB-1:0]   user_q;
    logic [`MX_IN_W-1:0]      in_data_q;
    logic                     in_valid_q;
    logic [`MX_OSC_RES-1:0]   osc_i_q;
    logic [`MX_OSC_RES-1:0]   osc_q_q;
    logic                     osc_valid_q;
    logic [OUT_RES-1:0]       cap_i_q;
    logic [OUT_RES-1:0]       cap_q_q;
    logic [`MX_USER_W-1:0]    cap_user_q;
    logic                     seen_q;
    logic [7:0]               cnt_q;
    logic                     take;
    logic                     wr_hit;

    assign take   = hsel && htrans[1] && hready;
    assign wr_hit = wr_q && hready;

    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        case (a)
            `MX_A_CTRL:   return {30'h0, mode_q};
            `MX_A_SAMPLE: return {16'h0, in_data_q};
            `MX_A_USER0:  return user_q[31:0];
            `MX_A_USER1:  return user_q[63:32];
            `MX_A_USER2:  return user_q[95:64];
            `MX_A_USER3:  return {24'h0, user_q[`MX_CHAN_MSB:`MX_CHAN_LSB]};
            `MX_A_OSC_I:  return {14'h0, osc_i_q};
            `MX_A_OSC_Q:  return {14'h0, osc_q_q};
            `MX_A_OUT_I:  return 32'(cap_i_q);
            `MX_A_OUT_Q:  return 32'(cap_q_q);
            `MX_A_OUT_TS: return cap_user_q[31:0];
            `MX_A_STATUS: return {cap_user_q[`MX_CHAN_MSB:`MX_CHAN_LSB], 8'h0, cnt_q, 7'h0, seen_q};
            default:      return 32'h0;
        endcase
    endfunction : rd_mux

    // ==========================================================
    // bus phases; reads take one wait state so a write just before lands first
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q        <= 1'b0;
            rd_q        <= 1'b0;
            addr_q      <= 8'h00;
            hreadyout_q <= 1'b1;
            hrdata_q    <= 32'h0;
        end else begin
            if (hready) begin
                wr_q   <= take && hwrite;
                rd_q   <= take && !hwrite;
                addr_q <= haddr[7:0];
            end
            hreadyout_q <= !(take && !hwrite);
            if (rd_q && !hreadyout_q) begin
                hrdata_q <= rd_mux(addr_q);
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q  <= mx_mode_t'(`MX_MODE_RST);
            user_q  <= '0;
            osc_i_q <= '0;
            osc_q_q <= '0;
        end else if (wr_hit) begin
            case (addr_q)
                `MX_A_CTRL:  mode_q <= mx_mode_t'(hwdata[1:0]);
                `MX_A_USER0: user_q[31:0] <= hwdata;
                `MX_A_USER1: user_q[`MX_TS_MSB:32] <= hwdata;
                `MX_A_USER2: user_q[95:64] <= hwdata;
                `MX_A_USER3: user_q[`MX_CHAN_MSB:`MX_CHAN_LSB] <= hwdata[7:0];
                `MX_A_OSC_I: osc_i_q <= hwdata[`MX_OSC_RES-1:0];
                `MX_A_OSC_Q: osc_q_q <= hwdata[`MX_OSC_RES-1:0];
                default: begin
                end
            endcase
        end
    end

    // ==========================================================
    // stream beats: one write fires exactly one valid cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            in_data_q   <= '0;
            in_valid_q  <= 1'b0;
            osc_valid_q <= 1'b0;
        end else begin
            in_valid_q  <= wr_hit && (addr_q == `MX_A_SAMPLE);
            osc_valid_q <= wr_hit && (addr_q == `MX_A_OSC_Q);
            if (wr_hit && (addr_q == `MX_A_SAMPLE)) begin
                in_data_q <= hwdata[`MX_IN_W-1:0];
            end
        end
    end

    // ==========================================================
    // result capture; no ready exists, so every beat is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_i_q    <= '0;
            cap_q_q    <= '0;
            cap_user_q <= '0;
            cnt_q      <= 8'h00;
        end else if (lnk.out_valid) begin
            cap_i_q    <= lnk.out_data[OUT_RES-1:0];
            cap_q_q    <= lnk.out_data[2*OUT_RES-1:OUT_RES];
            cap_user_q <= lnk.out_user;
            cnt_q      <= cnt_q + 8'h01;
        end
    end

    // a result in the clearing cycle keeps the flag set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seen_q <= 1'b0;
        end else if (lnk.out_valid) begin
            seen_q <= 1'b1;
        end else if (wr_hit && (addr_q == `MX_A_STATUS) && hwdata[0]) begin
            seen_q <= 1'b0;
        end
    end

    // ==========================================================
    // outputs
    assign hreadyout     = hreadyout_q;
    assign hresp         = 1'b0;
    assign hrdata        = hrdata_q;
    assign lnk.mode      = mode_q;
    assign lnk.in_data   = in_data_q;
    assign lnk.in_valid  = in_valid_q;
    // reserved sideband bits always go out as zero
    assign lnk.in_user   = {`MX_RSV_W'(0), user_q};
    assign lnk.osc_data  = {6'h0, osc_q_q, 6'h0, osc_i_q};
    assign lnk.osc_valid = osc_valid_q;

endmodule : mx_peer

/* File: verification/mx_link_assertions.sv */
// concurrent checks on the stream link between mixer and peer
`timescale 1ns/100ps
`include "mx_defs.svh"

module mx_link_assertions
    import mx_pkg::*;
#(
    parameter int OUT_RES = `MX_OUT_RES_DEF
)(
    input wire logic                  hclk,
    input wire logic                  hresetn,
    input wire logic [`MX_IN_W-1:0]   in_data,
    input wire logic                  in_valid,
    input wire logic [`MX_USER_W-1:0] in_user,
    input wire logic [`MX_OSC_W-1:0]  osc_data,
    input wire logic                  osc_valid,
    input wire logic [2*OUT_RES-1:0]  out_data,
    input wire logic                  out_valid,
    input wire logic [`MX_USER_W-1:0] out_user,
    input wire mx_mode_t              mode
);
    // ========================================================
    // reference results; oscillator copy lags one edge like the mixer
    logic signed [17:0]  osc_i_q;
    logic signed [17:0]  osc_q_q;
    logic signed [33:0]  byp_w;
    logic signed [33:0]  mi_w;
    logic signed [33:0]  mq_w;
    logic [OUT_RES-1:0]  byp_t;
    logic [OUT_RES-1:0]  mi_t;
    logic [OUT_RES-1:0]  mq_t;
    logic signed [33:0]  oi_w;
    logic signed [33:0]  oq_w;
    logic [OUT_RES-1:0]  oi_t;
    logic [OUT_RES-1:0]  oq_t;

    always_ff @(posedge hclk) begin
        if (!hresetn) begin
            osc_i_q <= '0;
            osc_q_q <= '0;
        end else if (osc_valid) begin
            osc_i_q <= osc_data[17:0];
            osc_q_q <= osc_data[41:24];
        end
    end

    assign byp_w = {in_data[15], in_data, 17'h0};
    assign mi_w  = $signed(in_data) * osc_i_q;
    assign mq_w  = $signed(in_data) * osc_q_q;
    assign byp_t = byp_w[32 -: OUT_RES];
    assign mi_t  = mi_w[32 -: OUT_RES];
    assign mq_t  = mq_w[32 -: OUT_RES];
    // oscillator mode: held sample scaled to the same full-scale bits
    assign oi_w  = {osc_i_q[17], osc_i_q, 15'h0};
    assign oq_w  = {osc_q_q[17], osc_q_q, 15'h0};
    assign oi_t  = oi_w[32 -: OUT_RES];
    assign oq_t  = oq_w[32 -: OUT_RES];

    // ========================================================
    // properties
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    out_follows_a: assert property (in_valid |=> out_valid)
        else $error("no output beat after input beat");
    out_cause_a: assert property (out_valid |-> $past(in_valid))
        else $error("output beat without input beat");
    user_fwd_a: assert property (in_valid |=> out_user == $past(in_user))
        else $error("sideband not forwarded with its sample");
    out_hold_a: assert property (!in_valid |=> $stable(out_data) && $stable(out_user))
        else $error("output changed without input beat");
    bypass_a: assert property (in_valid && mode == MX_BYPASS
        |=> out_data == {{OUT_RES{1'b0}}, $past(byp_t)})
        else $error("bypass result wrong");
    mix_a: assert property (in_valid && mode == MX_MIX
        |=> out_data == {$past(mq_t), $past(mi_t)})
        else $error("mixer result wrong");
    zero_mode_a: assert property (in_valid && mode == MX_ZERO |=> out_data == '0)
        else $error("zero mode output not zero");
    osc_mode_a: assert property (in_valid && mode == MX_OSC
        |=> out_data == {$past(oq_t), $past(oi_t)})
        else $error("oscillator mode result wrong");
    mode_rst_a: assert property ($rose(hresetn) |-> mode == MX_BYPASS)
        else $error("mode not bypass after reset");
    rsv_zero_a: assert property (in_valid |-> in_user[127:104] == '0)
        else $error("reserved sideband bits set");
    osc_pack_a: assert property (osc_valid |-> osc_data[47:42] == '0 && osc_data[23:18] == '0)
        else $error("oscillator word padding not zero");
endmodule : mx_link_assertions

/* File: verification/test_stream_mixer_interfaces.sv */
// self-checking bench: AHB-Lite master feeds peer, peer and mixer share the link
`timescale 1ns/100ps
`include "mx_defs.svh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin errors++; \
    $display("unexpected %s: expected %h seen %h", n, e, s); end end

module test_stream_mixer_interfaces
    import mx_pkg::*;
;
    logic         hclk    = 1'b0;
    logic         hresetn = 1'b0;
    logic         hsel    = 1'b0;
    logic         hwrite  = 1'b0;
    logic         rd_dp   = 1'b0;
    logic [1:0]   htrans  = 2'h0;
    logic [31:0]  haddr   = 32'h0;
    logic [31:0]  hwdata  = 32'h0;
    logic [31:0]  hrdata;
    logic         hready;
    logic         hresp;
    logic [31:0]  exp_r;
    logic [159:0] exp_s;
    logic [31:0]  rd_q[$];
    logic [159:0] st_q[$];
    int           errors = 0;
    int           samples_checked = 0;
    int           seed = 59;

    mx_if #(.OUT_RES(16)) lnk ();
    mx_mixer #(.OUT_RES(16)) i_mx_mixer (.hclk(hclk), .hresetn(hresetn), .lnk(lnk));
    mx_peer #(.OUT_RES(16)) i_mx_peer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hready), .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .lnk(lnk));
    mx_link_assertions #(.OUT_RES(16)) u_link_chk (.hclk(hclk), .hresetn(hresetn),
        .in_data(lnk.in_data), .in_valid(lnk.in_valid), .in_user(lnk.in_user),
        .osc_data(lnk.osc_data), .osc_valid(lnk.osc_valid), .out_data(lnk.out_data),
        .out_valid(lnk.out_valid), .out_user(lnk.out_user), .mode(lnk.mode));

    // ========================================================
    // bus master and reference
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr  <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        rd_dp  <= !wr;
        do @(posedge hclk); while (hready !== 1'b1);
        rd_dp  <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        xfer(1'b0, a, 32'h0);
    endtask : rd

    function automatic logic [31:0] ex(int m, logic signed [15:0] s,
                                       logic signed [17:0] i, logic signed [17:0] q);
        logic signed [33:0] vi;
        logic signed [33:0] vq;
        vi = '0;
        vq = '0;
        case (m)
            0: vi = 34'(s) <<< 17;
            1: begin
                vi = s * i;
                vq = s * q;
            end
            2: begin
                vi = 34'(i) <<< 15;
                vq = 34'(q) <<< 15;
            end
            default: ;
        endcase
        return {vq[32:17], vi[32:17]};
    endfunction : ex

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : finish_test

    // ========================================================
    // result watchers take the oldest note at each result
    always @(posedge hclk) begin
        if (rd_dp && hready === 1'b1) begin
            exp_r = rd_q.pop_front();
            `CHK("hrdata", exp_r, hrdata)
            `CHK("hresp", 1'b0, hresp)
        end
        if (lnk.out_valid === 1'b1) begin
            exp_s = st_q.pop_front();
            `CHK("out_data", exp_s[159:128], lnk.out_data)
            `CHK("out_user", exp_s[127:0], lnk.out_user)
        end
    end

    initial begin
        forever #25 hclk = ~hclk;
    end

    // whole run needs a few hundred cycles
    initial begin
        #(50 * 4000);
        errors++;
        finish_test();
    end

    initial begin
        logic [15:0] s;
        logic [17:0] i;
        logic [17:0] q;
        mx_user_t    u;
        logic [31:0] e;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        rd(`MX_A_CTRL, 32'h0);
        xfer(1'b1, 8'h40, 32'hFFFF_FFFF);
        rd(8'h40, 32'h0);
        // one pass per mode; format, phase and type codes follow the mode number
        for (int m = 0; m < 4; m++) begin
            s = $random(seed);
            i = $random(seed);
            q = $random(seed);
            u = {$random(seed), $random(seed), $random(seed), $random(seed)};
            u.rsv = '0;
            u.fmt = mx_fmt_t'(m);
            u.quad = m[0];
            u.cplx = m[1];
            xfer(1'b1, `MX_A_CTRL, m);
            rd(`MX_A_CTRL, m);
            xfer(1'b1, `MX_A_OSC_I, {14'h0, i});
            xfer(1'b1, `MX_A_OSC_Q, {14'h0, q});
            xfer(1'b1, `MX_A_USER0, u[31:0]);
            xfer(1'b1, `MX_A_USER1, u[63:32]);
            xfer(1'b1, `MX_A_USER2, u[95:64]);
            xfer(1'b1, `MX_A_USER3, {24'h0, u.chan});
            e = ex(m, s, i, q);
            st_q.push_back({e, u});
            xfer(1'b1, `MX_A_SAMPLE, {16'h0, s});
            rd(`MX_A_OUT_TS, u[31:0]);
            rd(`MX_A_OUT_I, {16'h0, e[15:0]});
            rd(`MX_A_OUT_Q, {16'h0, e[31:16]});
            $display("mode test %0d done", m);
        end
        rd(`MX_A_STATUS, {u.chan, 8'h00, 8'h04, 8'h01});
        xfer(1'b1, `MX_A_STATUS, 32'h1);
        rd(`MX_A_STATUS, {u.chan, 8'h00, 8'h04, 8'h00});
        $display("status test done");
        @(posedge hclk);
        `CHK("pending", 0, rd_q.size() + st_q.size())
        finish_test();
    end
endmodule : test_stream_mixer_interfaces
